// ===== design/smcg_top.sv
// Top of the sleep-mode clock gating and wake-up control block.
// Assumes core strobes and wake events are on ref_clk_i; pin wakes are synchronised here.
`timescale 1ns/1ps
module smcg_top (
  input wire logic ref_clk_i,               // 40 MHz clock
  input wire logic nrst_i,                  // Sync reset, active low
  input wire logic sleep_exec_i,            // Sleep instruction strobe
  input wire logic sleep_enable_i,          // Sleep enable bit
  input wire logic [2:0] sleep_mode_select_i, // Mode field
  input wire logic timer0_async_select_i,   // Timer0 async select
  input wire logic xtal_selected_i,         // Crystal source chosen
  input wire logic [3:0] clock_source_fuses_i, // Start-up delay select
  input wire logic brownout_enable_fuse_i,  // Brown-out fuse
  input wire logic wdt_enable_i,            // Watchdog enable
  input wire logic adc_enable_i,            // Converter enable bit
  input wire logic acmp_enable_i,           // Comparator enable
  input wire logic acmp_use_ref_i,          // Comparator uses internal ref
  input wire logic [7:0] external_interrupt_lines_i, // Pin interrupts
  input wire logic [7:4] ext_level_mode_i,  // Level mode for 7..4
  input wire logic two_wire_match_i,        // Two-wire address match
  input wire logic timer0_irq_i,            // Timer0 event
  input wire logic mem_ready_irq_i,         // Store/eeprom ready
  input wire logic adc_irq_i,               // Conversion done
  input wire logic other_io_irq_i,          // Other I/O events
  output logic clk_cpu_en_o,                // Processor clock enable
  output logic clk_flash_en_o,              // Program memory clock enable
  output logic clk_io_en_o,                 // I/O clock enable
  output logic clk_adc_en_o,                // Converter clock enable
  output logic async_timer_clock_en_o,      // Async timer clock enable
  output logic main_osc_en_o,               // Main oscillator enable
  output logic timer_osc_en_o,              // Timer oscillator enable
  output logic adc_power_o,                 // Converter powered
  output logic adc_extended_o,              // Next conversion extended
  output logic acmp_power_o,                // Comparator powered
  output logic vref_en_o,                   // Internal reference on
  output logic bod_en_o,                    // Brown-out detector on
  output logic wdt_run_o,                   // Watchdog running
  output logic inbuf_en_o,                  // General input buffers
  output logic [7:0] wake_inbuf_en_o,       // Wake pin buffers
  output logic async_undef_o,               // Async timer contents undefined
  output logic sleeping_o                   // Block asleep
);
  smcg_pkg::smcg_state_e state_q, state_d;
  logic [2:0] mode_q;
  logic [7:0] pin_s1_q, pin_s2_q;
  logic adc_en_prev_q;
  logic wake_ok;
  logic ext_wake;
  logic wait_load;
  logic wait_done;
  logic [smcg_pkg::CNT_W-1:0] wait_val;
  logic mode_legal;
  smcg_gate_if gate ();

  // Two-stage synchroniser for the asynchronous interrupt pins
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else begin
      pin_s1_q <= external_interrupt_lines_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Unlisted codes 100/101, or standby without crystal, are not entered
  assign mode_legal = (sleep_mode_select_i[2:1] != 2'b10) &&
                      (!sleep_mode_select_i[2] || xtal_selected_i);

  smcg_decode u_decode (
    .sleeping_i (state_q != smcg_pkg::ST_RUN),
    .mode_i (mode_q),
    .async_i (timer0_async_select_i),
    .g (gate)
  );

  // Limited external set outside idle: 3..0 any, 7..4 only in level mode
  function automatic logic ext_hit(input logic [7:0] pins, input logic [7:4] lvl,
                                   input logic lim);
    ext_hit = lim ? ((|pins[3:0]) || (|(pins[7:4] & lvl))) : (|pins);
  endfunction
  assign ext_wake = ext_hit(pin_s2_q, ext_level_mode_i, gate.wake_ext_lim);

  // Qualified wake per mode
  assign wake_ok = two_wire_match_i || ext_wake ||
                   (gate.wake_t0 && timer0_irq_i) ||
                   (gate.wake_mem_adc && (mem_ready_irq_i || adc_irq_i)) ||
                   (gate.wake_io && other_io_irq_i);

  // Only power-down and power-save stop the oscillator and need start-up
  assign wait_val = mode_q[2] ? smcg_pkg::CNT_W'(smcg_pkg::STBY_WAKE_CYC)
                  : smcg_pkg::CNT_W'((clock_source_fuses_i + 1) * smcg_pkg::STARTUP_UNIT_CYC);
  assign wait_load = (state_q == smcg_pkg::ST_SLEEP) && wake_ok && gate.deep;

  smcg_wait u_wait (
    .ref_clk_i (ref_clk_i),
    .nrst_i (nrst_i),
    .load_i (wait_load),
    .val_i (wait_val),
    .done_o (wait_done)
  );

  // Sleep sequencing; shallow modes wake next cycle, deep ones wait
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      smcg_pkg::ST_RUN: begin
        if (sleep_exec_i && sleep_enable_i && mode_legal) state_d = smcg_pkg::ST_SLEEP;
      end
      smcg_pkg::ST_SLEEP: begin
        if (wake_ok) state_d = gate.deep ? smcg_pkg::ST_WAKE : smcg_pkg::ST_RESUME;
      end
      smcg_pkg::ST_WAKE: begin
        if (wait_done) state_d = smcg_pkg::ST_RESUME;
      end
      smcg_pkg::ST_RESUME: state_d = smcg_pkg::ST_RUN;
      default: state_d = smcg_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_q <= smcg_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Mode captured only on the sleep strobe
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      mode_q <= smcg_pkg::RST_MODE;
    end else if (state_q == smcg_pkg::ST_RUN && state_d == smcg_pkg::ST_SLEEP) begin
      mode_q <= sleep_mode_select_i;
    end
  end

  // Clock gate outputs; during wake wait the clocks stay gated
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      clk_cpu_en_o <= 1'b1;
      clk_flash_en_o <= 1'b1;
      clk_io_en_o <= 1'b1;
      clk_adc_en_o <= 1'b1;
      async_timer_clock_en_o <= 1'b0;
      main_osc_en_o <= 1'b1;
      timer_osc_en_o <= 1'b0;
      sleeping_o <= 1'b0;
    end else begin
      clk_cpu_en_o <= gate.cpu_run;
      clk_flash_en_o <= gate.flash_run;
      clk_io_en_o <= gate.io_run;
      clk_adc_en_o <= gate.adc_run;
      async_timer_clock_en_o <= gate.asy_run;
      // Oscillator must restart as soon as the start-up wait begins
      main_osc_en_o <= gate.main_osc || (state_q == smcg_pkg::ST_WAKE);
      timer_osc_en_o <= gate.tosc;
      sleeping_o <= (state_q != smcg_pkg::ST_RUN);
    end
  end

  // Analogue helpers and input buffers
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      adc_power_o <= 1'b0;
      acmp_power_o <= 1'b0;
      vref_en_o <= 1'b0;
      bod_en_o <= 1'b0;
      wdt_run_o <= 1'b0;
      inbuf_en_o <= 1'b1;
      wake_inbuf_en_o <= 8'hff;
    end else begin
      adc_power_o <= adc_enable_i;
      acmp_power_o <= acmp_enable_i && !gate.deep;
      // Comparator on reference keeps it on even when auto-disabled
      vref_en_o <= brownout_enable_fuse_i || adc_enable_i ||
                   (acmp_enable_i && acmp_use_ref_i);
      bod_en_o <= brownout_enable_fuse_i;
      wdt_run_o <= wdt_enable_i;
      inbuf_en_o <= gate.io_run || gate.adc_run;
      // Wake-capable pin buffers follow the wake qualification
      wake_inbuf_en_o <= (gate.io_run || gate.adc_run) ? 8'hff :
                         (gate.wake_ext_lim ? {ext_level_mode_i, 4'hf} : 8'hff);
    end
  end

  // Converter off-then-on arms one extended conversion
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      adc_en_prev_q <= 1'b0;
      adc_extended_o <= 1'b1;
    end else begin
      adc_en_prev_q <= adc_enable_i;
      if (adc_enable_i && !adc_en_prev_q) begin
        adc_extended_o <= 1'b1;
      end else if (adc_irq_i) begin
        adc_extended_o <= 1'b0;
      end
    end
  end

  // Async timer contents lost across power-save without async clock
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      async_undef_o <= 1'b0;
    end else if (state_q == smcg_pkg::ST_RUN && state_d == smcg_pkg::ST_SLEEP) begin
      async_undef_o <= (sleep_mode_select_i == smcg_pkg::MODE_PSAVE) &&
                       !timer0_async_select_i;
    end else if (timer0_async_select_i) begin
      async_undef_o <= 1'b0;
    end
  end

  // Checks
  sequence s_enter_sleep;
    state_q == smcg_pkg::ST_RUN && state_d == smcg_pkg::ST_SLEEP;
  endsequence
  sequence s_stby_wake;
    state_q == smcg_pkg::ST_SLEEP && wake_ok && mode_q[2];
  endsequence

  AST_CPU_GATED: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_enter_sleep |-> ##2 !clk_cpu_en_o && !clk_flash_en_o)
    else $error("cpu clock not gated after sleep");
  AST_STBY_SIX: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_stby_wake |-> ##7 state_q == smcg_pkg::ST_RESUME)
    else $error("standby wake latency wrong");
  AST_NO_STBY_XTAL: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_enter_sleep |-> !sleep_mode_select_i[2] || xtal_selected_i)
    else $error("standby entered without crystal");
  AST_MODE_HELD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    state_q != smcg_pkg::ST_RUN && $past(state_q) != smcg_pkg::ST_RUN |-> $stable(mode_q))
    else $error("mode changed while asleep");
  AST_ACMP_OFF: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    gate.deep |=> !acmp_power_o)
    else $error("comparator on in deep sleep");
  AST_BUF_OFF: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !gate.io_run && !gate.adc_run |=> !inbuf_en_o)
    else $error("input buffers on with clocks stopped");
  AST_ASY_PSAVE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    state_q == smcg_pkg::ST_SLEEP && mode_q == smcg_pkg::MODE_PSAVE |=>
    async_timer_clock_en_o == timer0_async_select_i && !clk_io_en_o)
    else $error("power-save gating wrong");
  AST_OSC_PDOWN: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    state_q == smcg_pkg::ST_SLEEP && mode_q == smcg_pkg::MODE_PDOWN |=> !main_osc_en_o)
    else $error("oscillator running in power-down");
  AST_BOD_KEPT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    brownout_enable_fuse_i |=> bod_en_o && vref_en_o)
    else $error("brown-out detector dropped");
endmodule

// ===== design/smcg_pkg.sv
// Package for the sleep-mode clock gating block: mode codes, states, timing.
// Assumes a single 40 MHz reference clock and a synchronous active-low reset.
//
// Contract
// - Decode mode field 000 idle, 001 noise reduction, 010 power-down, 011 power-save.
// - Power-down wake waits the fuse-selected start-up delay before taking effect.
// - Power-save with async select clear flags async timer contents undefined.
// - Power-save stops every domain except the async timer clock.
// - Mode 110 with crystal enters standby: power-down with main oscillator running.
// - Standby resumes six clock cycles after a valid wake event.
// - Mode 111 with crystal enters extended standby: power-save with oscillator running.
// - Extended standby resumes six clock cycles after a valid wake event.
// - Standby modes only exist when a crystal or resonator is selected.
// - Per-mode gating of processor, memory, I/O, converter and async domains.
// - Timer oscillator per async select, off in power-down and standby; main oscillator runs in idle, noise, standbys.
// - Wake sources qualified per mode: address match, timer0, memory ready, converter, I/O.
// - Outside idle only interrupts 3..0 or level interrupts 7..4 wake.
// - An enabled converter stays enabled in every sleep mode.
// - Converter switched off then on makes the next conversion extended.
// - Comparator automatically disabled in power-down, power-save and both standbys.
// - Comparator using internal reference keeps the reference on in all modes.
// - Internal reference on only while brown-out, comparator or converter needs it.
// - Fuse-enabled brown-out detector stays enabled in every sleep mode.
// - Enabled watchdog keeps running in every sleep mode.
// - Pin input buffers disabled when both I/O and converter clocks stop.
// - Wake-detect pin buffers stay enabled when other buffers are off.
package smcg_pkg;
  // Sleep mode field codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_NOISE = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_STBY = 3'h6;
  localparam logic [2:0] MODE_XSTBY = 3'h7;
  // Timing: standby wake latency in clock cycles
  localparam int STBY_WAKE_CYC = 6;
  // Start-up delay table step for power-down wake, selected by fuses
  localparam int STARTUP_UNIT_NS = 25000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int STARTUP_UNIT_CYC = (STARTUP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Widths and reset values
  localparam int CNT_W = 20;
  localparam logic [2:0] RST_MODE = 3'h0;
  // Controller states
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_WAKE = 4'h4,
    ST_RESUME = 4'h8
  } smcg_state_e;
endpackage

// ===== design/smcg_gate_if.sv
// Interface carrying the decoded gate set between decoder and top.
// Assumes both ends live in the ref_clk_i domain.
`timescale 1ns/1ps
interface smcg_gate_if;
  logic cpu_run;
  logic flash_run;
  logic io_run;
  logic adc_run;
  logic asy_run;
  logic main_osc;
  logic tosc;
  logic deep;
  logic wake_ext_lim;
  logic wake_t0;
  logic wake_mem_adc;
  logic wake_io;
  modport src (output cpu_run, flash_run, io_run, adc_run, asy_run, main_osc, tosc, deep,
               wake_ext_lim, wake_t0, wake_mem_adc, wake_io);
  modport dst (input cpu_run, flash_run, io_run, adc_run, asy_run, main_osc, tosc, deep,
               wake_ext_lim, wake_t0, wake_mem_adc, wake_io);
endinterface

// ===== design/smcg_decode.sv
// Combinational decode of one held sleep mode into clock and wake enables.
// Assumes mode and sleeping come from flip-flops of the top module.
`timescale 1ns/1ps
module smcg_decode (
  input wire logic sleeping_i,     // Block is asleep
  input wire logic [2:0] mode_i,   // Held mode field
  input wire logic async_i,        // Timer0 async select
  smcg_gate_if.src g               // Decoded gate set
);
  always_comb begin
    // Awake: synchronous clocks and main oscillator run, async ones per select; every source would wake
    g.cpu_run = 1'b1;
    g.flash_run = 1'b1;
    g.io_run = 1'b1;
    g.adc_run = 1'b1;
    g.asy_run = async_i;
    g.main_osc = 1'b1;
    g.tosc = async_i;
    g.deep = 1'b0;
    g.wake_ext_lim = 1'b0;
    g.wake_t0 = 1'b1;
    g.wake_mem_adc = 1'b1;
    g.wake_io = 1'b1;
    if (sleeping_i) begin
      g.cpu_run = 1'b0;
      g.flash_run = 1'b0;
      g.wake_ext_lim = (mode_i != smcg_pkg::MODE_IDLE);
      unique case (mode_i)
        smcg_pkg::MODE_IDLE: begin
        end
        smcg_pkg::MODE_NOISE: begin
          g.io_run = 1'b0;
          g.wake_io = 1'b0;
        end
        default: begin
          // Power-down, power-save and both standbys
          g.io_run = 1'b0;
          g.adc_run = 1'b0;
          g.deep = 1'b1;
          g.wake_io = 1'b0;
          g.wake_mem_adc = 1'b0;
          g.main_osc = mode_i[2];
          g.asy_run = async_i && mode_i[0];
          g.tosc = async_i && mode_i[0];
          g.wake_t0 = async_i && mode_i[0];
        end
      endcase
    end
  end
endmodule

// ===== design/smcg_wait.sv
// Loadable down counter that reports expiry of a wake-up delay.
// Assumes load and count enable from the same clock domain.
`timescale 1ns/1ps
module smcg_wait (
  input wire logic ref_clk_i,                    // 40 MHz clock
  input wire logic nrst_i,                       // Sync reset, active low
  input wire logic load_i,                       // Load start value
  input wire logic [smcg_pkg::CNT_W-1:0] val_i,  // Cycles to wait
  output logic done_o                            // Count reached one
);
  logic [smcg_pkg::CNT_W-1:0] cnt_q;
  // Count down; expiry flagged when reaching one to land on target edge
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= val_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  assign done_o = (cnt_q == {{(smcg_pkg::CNT_W-1){1'b0}}, 1'b1});
endmodule

// ===== sim/smcg_core_model.sv
// Behavioural model of the core and the peripherals that request wake-up.
// Assumes the bench calls its tasks from the falling edge of ref_clk_i.
`timescale 1ns/1ps
module smcg_core_model (
  input wire logic ref_clk_i,  // 40 MHz clock
  output logic sleep_exec_o,   // Sleep strobe, one cycle
  output logic [2:0] mode_o,   // Mode field
  output logic [4:0] wake_o    // Address match, timer0, mem ready, conversion, other I/O
);
  // Idle levels at time zero
  initial begin
    sleep_exec_o = 1'h0;
    mode_o = 3'h0;
    wake_o = 5'h00;
  end

  // Field flipped after the strobe, so a late sample of it shows up
  task automatic do_sleep(input logic [2:0] m);
    @(negedge ref_clk_i);
    mode_o = m;
    sleep_exec_o = 1'h1;
    @(negedge ref_clk_i);
    sleep_exec_o = 1'h0;
    mode_o = ~m;
  endtask

  // One-cycle event on one wake source
  task automatic pulse(input int idx);
    @(negedge ref_clk_i);
    wake_o[idx] = 1'h1;
    @(negedge ref_clk_i);
    wake_o = 5'h00;
  endtask
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the sleep-mode clock gating block.
// Assumes the core model drives strobes and wake events; the bench drives the rest.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i, nrst_i, sleep_exec, sleep_enable, async_sel, xtal, bod_fuse, wdt_en;
  logic adc_en, acmp_en, acmp_ref, cpu, flash, io, adcc, asy, mosc, tosc, adc_pw, adc_ext;
  logic acmp_pw, vref, bod, wdt, inbuf, undef, sleeping;
  logic [2:0] mode;
  logic [3:0] fuses;
  logic [7:0] ext_lines, wbuf;
  logic [7:4] lvl;
  logic [4:0] ev;
  logic [8:0] gate;
  logic [2:0] modes [6];
  int err_count, comparisons, n;

  assign gate = {cpu, flash, io, adcc, asy, mosc, tosc, inbuf, acmp_pw};

  // Clock, 25 ns period
  initial begin
    ref_clk_i = 1'h0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  smcg_core_model i_core (.ref_clk_i(ref_clk_i), .sleep_exec_o(sleep_exec), .mode_o(mode),
    .wake_o(ev));

  smcg_top i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sleep_exec_i(sleep_exec),
    .sleep_enable_i(sleep_enable), .sleep_mode_select_i(mode), .timer0_async_select_i(async_sel),
    .xtal_selected_i(xtal), .clock_source_fuses_i(fuses), .brownout_enable_fuse_i(bod_fuse),
    .wdt_enable_i(wdt_en), .adc_enable_i(adc_en), .acmp_enable_i(acmp_en),
    .acmp_use_ref_i(acmp_ref), .external_interrupt_lines_i(ext_lines), .ext_level_mode_i(lvl),
    .two_wire_match_i(ev[0]), .timer0_irq_i(ev[1]), .mem_ready_irq_i(ev[2]),
    .adc_irq_i(ev[3]), .other_io_irq_i(ev[4]), .clk_cpu_en_o(cpu), .clk_flash_en_o(flash),
    .clk_io_en_o(io), .clk_adc_en_o(adcc), .async_timer_clock_en_o(asy), .main_osc_en_o(mosc),
    .timer_osc_en_o(tosc), .adc_power_o(adc_pw), .adc_extended_o(adc_ext),
    .acmp_power_o(acmp_pw), .vref_en_o(vref), .bod_en_o(bod), .wdt_run_o(wdt),
    .inbuf_en_o(inbuf), .wake_inbuf_en_o(wbuf), .async_undef_o(undef), .sleeping_o(sleeping));

  // Single compare for every kind of value, zero-extended by the caller
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Expected gate set, comparator enabled: cpu, flash, io, adc, asy, main, tosc, inbuf, acmp
  function automatic logic [8:0] exp_gate(input logic [2:0] m, input logic a);
    logic deep;
    deep = m[1];
    exp_gate[8:7] = 2'h0;
    exp_gate[6] = (m == smcg_pkg::MODE_IDLE);
    exp_gate[5] = !deep;
    exp_gate[4] = a && (m != smcg_pkg::MODE_PDOWN) && (m != smcg_pkg::MODE_STBY);
    exp_gate[3] = (m != smcg_pkg::MODE_PDOWN) && (m != smcg_pkg::MODE_PSAVE);
    exp_gate[2] = exp_gate[4];
    exp_gate[1] = !deep;
    exp_gate[0] = !deep;
  endfunction

  // Counts clock edges from the wake edge until the processor clock is back
  task automatic wake_time(input int src);
    i_core.pulse(src);
    n = 0;
    while (cpu !== 1'h1 && n < 3000) begin
      @(negedge ref_clk_i);
      n++;
    end
    repeat (3) @(negedge ref_clk_i);
  endtask

  // Sleep, offer one source (0..4 core events, 5..12 pin lines), see whether it wakes
  task automatic qual(input logic [2:0] m, input int src, input logic woke);
    i_core.do_sleep(m);
    repeat (4) @(negedge ref_clk_i);
    chk("wake buffers", 20'(wbuf), 20'(m[1] ? {lvl, 4'hf} : 8'hff));
    if (src < 5) begin
      i_core.pulse(src);
    end else begin
      ext_lines[src-5] = 1'h1;
    end
    repeat (16) @(negedge ref_clk_i);
    chk("still asleep", 20'(sleeping), 20'(!woke));
    ext_lines = 8'h00;
    if (sleeping === 1'h1) begin
      i_core.pulse(0);
      repeat (16) @(negedge ref_clk_i);
    end
  endtask

  // Hang guard, well above the few thousand cycles the tests need
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    err_count++;
    $display("watchdog expired");
    results();
  end

  initial begin
    modes = '{smcg_pkg::MODE_IDLE, smcg_pkg::MODE_NOISE, smcg_pkg::MODE_PDOWN,
              smcg_pkg::MODE_PSAVE, smcg_pkg::MODE_STBY, smcg_pkg::MODE_XSTBY};
    {nrst_i, sleep_enable, async_sel, xtal, bod_fuse, wdt_en} = 6'h1f;
    {adc_en, acmp_en, acmp_ref, fuses, ext_lines, lvl} = {3'h6, 4'h0, 8'h00, 4'h0};
    err_count = 0;
    comparisons = 0;
    repeat (6) @(negedge ref_clk_i);
    chk("reset values", {gate[8:1], wbuf, adc_ext, sleeping}, {8'hf5, 8'hff, 2'h2});
    nrst_i = 1'h1;
    $display("test reset done");

    // Every legal mode, async select clear then set
    for (int i = 0; i < 12; i++) begin
      async_sel = i[0];
      i_core.do_sleep(modes[i/2]);
      repeat (4) @(negedge ref_clk_i);
      chk("gates", 20'(gate), 20'(exp_gate(modes[i/2], async_sel)));
      chk("kept on", 20'({sleeping, adc_pw, bod, wdt, undef}),
          20'({4'hf, modes[i/2] == smcg_pkg::MODE_PSAVE && !async_sel}));
      wake_time(0);
      if (modes[i/2] == smcg_pkg::MODE_PDOWN || modes[i/2] == smcg_pkg::MODE_PSAVE) begin
        chk("startup wait", 20'(n >= 1000 && n <= 1010), 20'h1);
      end else begin
        chk("wake latency", 20'(n), 20'(modes[i/2][1] ? smcg_pkg::STBY_WAKE_CYC + 2 : 2));
      end
      chk("running again", 20'(sleeping), 20'h0);
    end
    $display("test mode table done");

    // Refused requests
    i_core.do_sleep(3'h4);
    repeat (4) @(negedge ref_clk_i);
    chk("reserved code", 20'(sleeping), 20'h0);
    xtal = 1'h0;
    i_core.do_sleep(smcg_pkg::MODE_STBY);
    repeat (4) @(negedge ref_clk_i);
    chk("standby no crystal", 20'(sleeping), 20'h0);
    xtal = 1'h1;
    $display("test refusal done");

    // Wake qualification per mode
    qual(smcg_pkg::MODE_IDLE, 4, 1'h1);
    qual(smcg_pkg::MODE_NOISE, 4, 1'h0);
    qual(smcg_pkg::MODE_NOISE, 2, 1'h1);
    qual(smcg_pkg::MODE_NOISE, 3, 1'h1);
    qual(smcg_pkg::MODE_STBY, 1, 1'h0);
    qual(smcg_pkg::MODE_XSTBY, 1, 1'h1);
    qual(smcg_pkg::MODE_XSTBY, 2, 1'h0);
    qual(smcg_pkg::MODE_STBY, 7, 1'h1);
    qual(smcg_pkg::MODE_STBY, 10, 1'h0);
    lvl = 4'h2;
    qual(smcg_pkg::MODE_STBY, 10, 1'h1);
    lvl = 4'h0;
    qual(smcg_pkg::MODE_IDLE, 11, 1'h1);
    $display("test wake sources done");

    // Analogue helpers: reference, extended conversion, comparator in deep sleep
    {adc_en, acmp_en, bod_fuse, wdt_en} = 4'h0;
    repeat (3) @(negedge ref_clk_i);
    chk("helpers idle", 20'({vref, bod, wdt}), 20'h0);
    adc_en = 1'h1;
    repeat (3) @(negedge ref_clk_i);
    chk("reference and long conversion", 20'({vref, adc_ext}), 20'h3);
    i_core.pulse(3);
    repeat (3) @(negedge ref_clk_i);
    chk("long conversion cleared", 20'(adc_ext), 20'h0);
    {adc_en, acmp_en, acmp_ref} = 3'h3;
    i_core.do_sleep(smcg_pkg::MODE_PDOWN);
    repeat (4) @(negedge ref_clk_i);
    chk("comparator and reference", 20'({acmp_pw, vref}), 20'h1);
    wake_time(0);
    $display("test analogue done");
    results();
  end
endmodule
